/* File: hbls_consts.svh */
// field positions, offsets and reset values of the half-word transfer unit
`ifndef HBLS_CONSTS_SVH
`define HBLS_CONSTS_SVH

`define HBLS_BIT_PRE 24
`define HBLS_BIT_UP 23
`define HBLS_BIT_IMM 22
`define HBLS_BIT_WB 21
`define HBLS_BIT_LOAD 20
`define HBLS_BASE_HI 19
`define HBLS_BASE_LO 16
`define HBLS_DEST_HI 15
`define HBLS_DEST_LO 12
`define HBLS_OFFH_HI 11
`define HBLS_OFFH_LO 8
`define HBLS_BIT_SIGN 6
`define HBLS_BIT_HALF 5
`define HBLS_OFFL_HI 3
`define HBLS_OFFL_LO 0

`define HBLS_PC_INDEX 4'hF
`define HBLS_PC_BASE_ADJ 32'h0000_0008
`define HBLS_PC_STORE_ADJ 32'h0000_000C

`define HBLS_REG_STATUS 5'h10
`define HBLS_ST_BUSY 0
`define HBLS_ST_ABORT 1
`define HBLS_ST_ENDIAN 2
`define HBLS_ST_BADOP 3
`define HBLS_WORD_RESET 32'h0000_0000

`endif

/* File: hbls_core.sv */
// half-word and signed byte load/store sequencer
//
// How it works
// - immediate offset is bits 11..8 then 3..0; else index register.
// - up bit set adds offset to base, clear subtracts it.
// - pre-index addresses with modified base; post-index with old base.
// - pre-indexed transfers write back base only when write-back bit set.
// - post-indexed transfers write back unless base is pc; source leaves bit clear.
// - extend clear and size set gives unsigned half-word load or store.
// - extend set gives signed load; size bit picks byte or half-word.
// - signed byte fills bits 31..8 with the byte's bit 7.
// - signed half-word fills bits 31..16 with its bit 15.
// - unsigned half-word clears bits 31..16.
// - endian select chooses the little or big endian lane map.
// - little endian byte: offset 0 bits 7..0, offset 1 bits 15..8.
// - little endian half: bits 15..0, or 31..16 when address bit 1 set.
// - big endian byte: offset 0 bits 31..24, offset 1 bits 23..16.
// - big endian half: bits 31..16, or 15..0 when address bit 1 set.
// - store drives source low half on both bus halves; memory picks one.
// - program counter as base reads instruction address plus 8.
// - program counter stored as source gives instruction address plus 12.
// - fault input during a transfer takes the abort, nothing retires.
// - loads 1S+1N+1I, loads into pc 2S+2N+1I, stores 2N.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`default_nettype none
`include "hbls_consts.svh"
module hbls_core
    import hbls_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic endian_select,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] instr_addr,
    output logic instr_ack,
    output logic busy,
    output logic done,
    output logic data_abort,
    output logic mem_req,
    output logic mem_write,
    output logic mem_half,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output hbls_cyc_e cyc_type,
    input wire logic [31:0] mem_rdata,
    input wire logic fault_input,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    if (DATA_W != 32)
    begin : g_chk
        $error("hbls_core supports a 32-bit data bus only");
    end

    function automatic hbls_op_e hbls_decode(input logic [31:0] w);
        if (!w[`HBLS_BIT_LOAD])
            return w[`HBLS_BIT_HALF] ? OP_ST_HALF : OP_NONE;
        else if (w[`HBLS_BIT_SIGN])
            return w[`HBLS_BIT_HALF] ? OP_LD_HALF_S : OP_LD_BYTE_S;
        else if (w[`HBLS_BIT_HALF])
            return OP_LD_HALF_U;
        else
            return OP_NONE;
    endfunction : hbls_decode

    hbls_state_e st_ff, nxt_st;
    logic endian_meta_ff, endian_ff;
    logic [31:0] iw_ff;
    logic [31:0] pc_ff;
    hbls_op_e op_ff;
    logic [31:0] addr_ff;
    logic [31:0] wb_val_ff;
    logic wb_en_ff;
    logic abort_sticky_ff, badop_sticky_ff;
    logic instr_ack_ff, busy_ff, done_ff, abort_ff;
    logic mem_req_ff, mem_write_ff, mem_half_ff;
    logic [31:0] mem_addr_ff, mem_wdata_ff;
    hbls_cyc_e cyc_ff;

    logic accept;
    logic [31:0] rd_base, rd_index, rd_src;
    logic [31:0] base_val, offset, modified, xfer_addr, src_val;
    logic [3:0] base_idx, dest_idx;
    logic fin_ok, fault_now;
    logic core_we_a, core_we_b;
    logic sw_wr_reg, status_wr;
    logic [31:0] status_word;

    hbls_lane_if lif ();

    hbls_lane u_lane (
        .lif(lif.lane)
    );

    // endian strap is a pin: two flops before use
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            endian_meta_ff <= 1'b0;
            endian_ff <= 1'b0;
        end
        else
        begin
            endian_meta_ff <= endian_select;
            endian_ff <= endian_meta_ff;
        end
    end

    // a register bus access in the same cycle holds the instruction off
    assign accept = instr_valid && (st_ff == ST_IDLE) && !reg_wr && !reg_rd;
    assign base_idx = iw_ff[`HBLS_BASE_HI:`HBLS_BASE_LO];
    assign dest_idx = iw_ff[`HBLS_DEST_HI:`HBLS_DEST_LO];

    assign base_val = (base_idx == `HBLS_PC_INDEX) ?
        pc_ff + `HBLS_PC_BASE_ADJ : rd_base;
    assign src_val = (dest_idx == `HBLS_PC_INDEX) ?
        pc_ff + `HBLS_PC_STORE_ADJ : rd_src;
    assign offset = iw_ff[`HBLS_BIT_IMM] ?
        {24'h00_0000, iw_ff[`HBLS_OFFH_HI:`HBLS_OFFH_LO],
         iw_ff[`HBLS_OFFL_HI:`HBLS_OFFL_LO]} : rd_index;
    assign modified = iw_ff[`HBLS_BIT_UP] ?
        base_val + offset : base_val - offset;
    assign xfer_addr = iw_ff[`HBLS_BIT_PRE] ?
        modified : base_val;

    assign lif.endian_big = endian_ff;
    assign lif.byte_sel = addr_ff[1:0];
    assign lif.op = op_ff;
    assign lif.bus_rdata = mem_rdata;
    assign lif.store_src = src_val;

    // the memory answers in the cycle after the request
    assign fault_now = fault_input &&
        (st_ff == ST_LI || (st_ff == ST_PN && op_ff == OP_ST_HALF));

    always_comb
    begin
        nxt_st = st_ff;
        fin_ok = 1'b0;
        unique case (st_ff)
            ST_IDLE:
                if (accept)
                    nxt_st = ST_CALC;
            ST_CALC:
                if (op_ff == OP_NONE)
                begin
                    nxt_st = ST_IDLE;
                    fin_ok = 1'b1;
                end
                else
                    nxt_st = ST_N1;
            ST_N1:
                nxt_st = (op_ff == OP_ST_HALF) ? ST_PN : ST_LI;
            ST_LI:
                if (fault_now)
                    nxt_st = ST_IDLE;
                else if (dest_idx == `HBLS_PC_INDEX)
                    nxt_st = ST_PN;
                else
                    nxt_st = ST_LS;
            ST_LS:
            begin
                nxt_st = ST_IDLE;
                fin_ok = 1'b1;
            end
            ST_PN:
                if (op_ff == OP_ST_HALF)
                begin
                    nxt_st = ST_IDLE;
                    fin_ok = !fault_now;
                end
                else
                    nxt_st = ST_PS1;
            ST_PS1:
                nxt_st = ST_PS2;
            ST_PS2:
            begin
                nxt_st = ST_IDLE;
                fin_ok = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            st_ff <= ST_IDLE;
        else
            st_ff <= nxt_st;
    end

    // instruction capture at acceptance
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            iw_ff <= `HBLS_WORD_RESET;
            pc_ff <= `HBLS_WORD_RESET;
            op_ff <= OP_NONE;
        end
        else if (accept)
        begin
            iw_ff <= instr_word;
            pc_ff <= instr_addr;
            op_ff <= hbls_decode(instr_word);
        end
    end

    // address and write-back value fixed once the operands are read
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            addr_ff <= `HBLS_WORD_RESET;
            wb_val_ff <= `HBLS_WORD_RESET;
            wb_en_ff <= 1'b0;
        end
        else if (st_ff == ST_CALC)
        begin
            addr_ff <= xfer_addr;
            wb_val_ff <= modified;
            wb_en_ff <= (!iw_ff[`HBLS_BIT_PRE] ||
                iw_ff[`HBLS_BIT_WB]) &&
                (base_idx != `HBLS_PC_INDEX);
        end
    end

    // memory side outputs follow the state being entered
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mem_req_ff <= 1'b0;
            mem_write_ff <= 1'b0;
            mem_half_ff <= 1'b0;
            mem_addr_ff <= `HBLS_WORD_RESET;
            mem_wdata_ff <= `HBLS_WORD_RESET;
        end
        else if (nxt_st == ST_N1)
        begin
            mem_req_ff <= 1'b1;
            mem_write_ff <= (op_ff == OP_ST_HALF);
            mem_half_ff <= (op_ff != OP_LD_BYTE_S);
            mem_addr_ff <= xfer_addr;
            mem_wdata_ff <= (op_ff == OP_ST_HALF) ?
                lif.store_bus : `HBLS_WORD_RESET;
        end
        else
        begin
            mem_req_ff <= 1'b0;
            mem_write_ff <= 1'b0;
        end
    end

    // cycle class of each state, so loads and stores show their counts
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cyc_ff <= CYC_IDLE;
        else
        begin
            unique case (nxt_st)
                ST_N1, ST_PN: cyc_ff <= CYC_N;
                ST_LI: cyc_ff <= CYC_I;
                ST_LS, ST_PS1, ST_PS2: cyc_ff <= CYC_S;
                default: cyc_ff <= CYC_IDLE;
            endcase
        end
    end

    // nothing retires on a fault, so the instruction can simply restart
    assign core_we_a = (st_ff == ST_LI) && !fault_now;
    assign core_we_b = wb_en_ff && !fault_now &&
        ((st_ff == ST_LI) ||
         (st_ff == ST_PN && op_ff == OP_ST_HALF));
    assign sw_wr_reg = reg_wr && !reg_addr[4] && (st_ff == ST_IDLE);
    assign status_wr = reg_wr && (reg_addr == `HBLS_REG_STATUS);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            instr_ack_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            abort_ff <= 1'b0;
        end
        else
        begin
            instr_ack_ff <= accept;
            busy_ff <= (nxt_st != ST_IDLE);
            done_ff <= fin_ok;
            abort_ff <= fault_now;
        end
    end

    // sticky status: a new event beats a clear in the same cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            abort_sticky_ff <= 1'b0;
            badop_sticky_ff <= 1'b0;
        end
        else
        begin
            if (fault_now)
                abort_sticky_ff <= 1'b1;
            else if (status_wr && reg_wdata[`HBLS_ST_ABORT])
                abort_sticky_ff <= 1'b0;
            if (st_ff == ST_CALC && op_ff == OP_NONE)
                badop_sticky_ff <= 1'b1;
            else if (status_wr && reg_wdata[`HBLS_ST_BADOP])
                badop_sticky_ff <= 1'b0;
        end
    end

    always_comb
    begin
        status_word = `HBLS_WORD_RESET;
        status_word[`HBLS_ST_BUSY] = busy_ff;
        status_word[`HBLS_ST_ABORT] = abort_sticky_ff;
        status_word[`HBLS_ST_ENDIAN] = endian_ff;
        status_word[`HBLS_ST_BADOP] = badop_sticky_ff;
    end

    hbls_regfile #(
        .DEPTH(16),
        .WIDTH(32)
    ) u_regs (
        .clk(mclk),
        .rst(rst),
        .rd_addr_a(instr_word[`HBLS_BASE_HI:`HBLS_BASE_LO]),
        .rd_addr_b(instr_word[`HBLS_OFFL_HI:`HBLS_OFFL_LO]),
        .rd_addr_c(instr_word[`HBLS_DEST_HI:`HBLS_DEST_LO]),
        .rd_data_a(rd_base),
        .rd_data_b(rd_index),
        .rd_data_c(rd_src),
        .sw_rd(reg_rd),
        .sw_addr(reg_addr),
        .sw_extra(status_word),
        .sw_rdata(reg_rdata),
        .we_a(core_we_a || sw_wr_reg),
        .wa_a(core_we_a ? dest_idx : reg_addr[3:0]),
        .wd_a(core_we_a ? lif.load_result : reg_wdata),
        .we_b(core_we_b),
        .wa_b(base_idx),
        .wd_b(wb_val_ff)
    );

    assign instr_ack = instr_ack_ff;
    assign busy = busy_ff;
    assign done = done_ff;
    assign data_abort = abort_ff;
    assign mem_req = mem_req_ff;
    assign mem_write = mem_write_ff;
    assign mem_half = mem_half_ff;
    assign mem_addr = mem_addr_ff;
    assign mem_wdata = mem_wdata_ff;
    assign cyc_type = cyc_ff;
endmodule : hbls_core
`default_nettype wire

/* File: hbls_core_props.sv */
// concurrent checks on the ports of the half-word transfer unit
`default_nettype none
module hbls_core_props
    import hbls_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic instr_ack,
    input wire logic busy,
    input wire logic done,
    input wire logic data_abort,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_wdata,
    input wire hbls_cyc_e cyc_type,
    input wire logic fault_input,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // refused encodings retire without a transfer, so they are left out
    function automatic logic legal(input logic [31:0] iw);
        return iw[5] | (iw[6] & iw[20]);
    endfunction : legal
    AST_ACCEPT: assert property (
        instr_valid && !busy && !reg_wr && !reg_rd |=> instr_ack)
        else $error("idle offer not acknowledged");
    AST_REQ: assert property (
        instr_ack && legal($past(instr_word)) |=> mem_req)
        else $error("no transfer after acknowledge");
    AST_REPL: assert property (
        mem_req && mem_write |-> mem_wdata[31:16] == mem_wdata[15:0])
        else $error("store halves differ");
    AST_LD_NI: assert property (
        mem_req && !mem_write |-> cyc_type == CYC_N ##1 cyc_type == CYC_I)
        else $error("load cycle types wrong");
    AST_ST_NN: assert property (
        mem_req && mem_write |-> cyc_type == CYC_N ##1 cyc_type == CYC_N
        ##1 (done || data_abort))
        else $error("store cycle types wrong");
    AST_ABORT: assert property (
        mem_req ##1 fault_input |=> data_abort && !done && !busy)
        else $error("fault not turned into abort");
    AST_LD_DONE: assert property (
        mem_req && !mem_write ##1 !fault_input ##1 cyc_type == CYC_S
        |=> done && !data_abort)
        else $error("load did not retire after its S cycle");
    AST_PC_LD: assert property (
        mem_req && !mem_write ##1 !fault_input ##1 cyc_type == CYC_N
        |=> (cyc_type == CYC_S) [*2] ##1 done)
        else $error("load into pc cycle types wrong");
    AST_RD_ZERO: assert property (
        !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    cover property (mem_req && mem_write ##1 fault_input);
    cover property (mem_req && !mem_write ##1 !fault_input ##3 done);
    cover property (mem_req && !mem_write ##2 cyc_type == CYC_N);
endmodule : hbls_core_props
bind hbls_core hbls_core_props u_props (.mclk(mclk), .rst(rst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ack(instr_ack), .busy(busy), .done(done),
    .data_abort(data_abort), .mem_req(mem_req), .mem_write(mem_write),
    .mem_wdata(mem_wdata), .cyc_type(cyc_type),
    .fault_input(fault_input), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
`default_nettype wire

/* File: hbls_lane.sv */
// byte and half-word lane selection, extension and store replication
`default_nettype none
module hbls_lane
    import hbls_pkg::*;
(
    hbls_lane_if.lane lif
);
    function automatic logic [7:0] hbls_pick_byte(
        input logic [31:0] data,
        input logic [1:0] sel,
        input logic big
    );
        logic [1:0] lane;
        lane = big ? 2'h3 - sel : sel;
        return data[{lane, 3'h0} +: 8];
    endfunction : hbls_pick_byte

    function automatic logic [15:0] hbls_pick_half(
        input logic [31:0] data,
        input logic a1,
        input logic big
    );
        return (a1 ^ big) ? data[31:16] : data[15:0];
    endfunction : hbls_pick_half

    logic [7:0] sel_byte;
    logic [15:0] sel_half;

    // little endian walks upward from bits 7..0, big endian downward
    assign sel_byte = hbls_pick_byte(lif.bus_rdata, lif.byte_sel,
        lif.endian_big);
    assign sel_half = hbls_pick_half(lif.bus_rdata, lif.byte_sel[1],
        lif.endian_big);

    always_comb
    begin
        unique case (lif.op)
            OP_LD_BYTE_S: lif.load_result = {{24{sel_byte[7]}},
                sel_byte};
            OP_LD_HALF_S: lif.load_result = {{16{sel_half[15]}},
                sel_half};
            OP_LD_HALF_U: lif.load_result = {16'h0000,
                sel_half};
            default: lif.load_result = 32'h0000_0000;
        endcase
    end

    // memory picks the half it needs, so both halves carry the data
    assign lif.store_bus = {lif.store_src[15:0],
        lif.store_src[15:0]};
endmodule : hbls_lane
`default_nettype wire

/* File: hbls_lane_if.sv */
// lane selection signals between the core sequencer and the lane unit
`default_nettype none
interface hbls_lane_if;
    import hbls_pkg::*;
    logic endian_big;
    logic [1:0] byte_sel;
    hbls_op_e op;
    logic [31:0] bus_rdata;
    logic [31:0] store_src;
    logic [31:0] load_result;
    logic [31:0] store_bus;
    modport core (
        output endian_big,
        output byte_sel,
        output op,
        output bus_rdata,
        output store_src,
        input load_result,
        input store_bus
    );
    modport lane (
        input endian_big,
        input byte_sel,
        input op,
        input bus_rdata,
        input store_src,
        output load_result,
        output store_bus
    );
endinterface : hbls_lane_if
`default_nettype wire

/* File: hbls_mem_model.sv */
// memory and memory-manager model answering the transfer unit
`default_nettype none
module hbls_mem_model
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] rd_word,
    input wire logic fault_cmd,
    output logic [31:0] mem_rdata,
    output logic fault_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // data only holds in the answer cycle; elsewhere it toggles every cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mem_rdata <= 32'h0;
            fault_input <= 1'b0;
        end
        else if (mem_req)
        begin
            mem_rdata <= mem_write ? ~rd_word : rd_word;
            fault_input <= fault_cmd;
        end
        else
        begin
            mem_rdata <= ~mem_rdata;
            fault_input <= 1'b0;
        end
    end
endmodule : hbls_mem_model
`default_nettype wire

/* File: hbls_pkg.sv */
// types shared by the half-word transfer unit
`default_nettype none
package hbls_pkg;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_LD_HALF_U,
        OP_LD_HALF_S,
        OP_LD_BYTE_S,
        OP_ST_HALF
    } hbls_op_e;

    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_N,
        CYC_S,
        CYC_I
    } hbls_cyc_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CALC,
        ST_N1,
        ST_LI,
        ST_LS,
        ST_PN,
        ST_PS1,
        ST_PS2
    } hbls_state_e;
endpackage : hbls_pkg
`default_nettype wire

/* File: hbls_regfile.sv */
// register file: three core read ports, one software port, two writes
`default_nettype none
module hbls_regfile #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] rd_addr_a,
    input wire logic [3:0] rd_addr_b,
    input wire logic [3:0] rd_addr_c,
    output logic [WIDTH-1:0] rd_data_a,
    output logic [WIDTH-1:0] rd_data_b,
    output logic [WIDTH-1:0] rd_data_c,
    input wire logic sw_rd,
    input wire logic [4:0] sw_addr,
    input wire logic [WIDTH-1:0] sw_extra,
    output logic [WIDTH-1:0] sw_rdata,
    input wire logic we_a,
    input wire logic [3:0] wa_a,
    input wire logic [WIDTH-1:0] wd_a,
    input wire logic we_b,
    input wire logic [3:0] wa_b,
    input wire logic [WIDTH-1:0] wd_b
);
    if (DEPTH != 16 || WIDTH != 32)
    begin : g_chk
        $error("hbls_regfile serves 16 words of 32 bits only");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // port a written last so it wins when both hit one register
    always_ff @(posedge clk)
    begin
        if (we_b)
            mem[wa_b] <= wd_b;
        if (we_a)
            mem[wa_a] <= wd_a;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_a <= '0;
            rd_data_b <= '0;
            rd_data_c <= '0;
        end
        else
        begin
            rd_data_a <= mem[rd_addr_a];
            rd_data_b <= mem[rd_addr_b];
            rd_data_c <= mem[rd_addr_c];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sw_rdata <= '0;
        else if (sw_rd)
            sw_rdata <= sw_addr[4] ? sw_extra : mem[sw_addr[3:0]];
        else
            sw_rdata <= '0;
    end
endmodule : hbls_regfile
`default_nettype wire

/* File: tb_halfword_byte_load_store.sv */
// self-checking bench of the half-word transfer unit
`default_nettype none
module tb_halfword_byte_load_store
    import hbls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst = 1'b1, endian_select = 1'b0;
    logic instr_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] instr_word = 32'h0, instr_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0, rd_word = 32'h0;
    logic [4:0] reg_addr = 5'h0;
    logic fault_cmd = 1'b0;
    logic instr_ack, busy, done, data_abort, mem_req, mem_write, mem_half;
    logic fault_input, cap_half;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, reg_rdata, cap_addr, cap_wd;
    logic [31:0] rv [16];
    hbls_cyc_e cyc_type;
    int error_cnt = 0, n_checks = 0;
    always #4 mclk = ~mclk;
    hbls_core dut (.mclk(mclk), .rst(rst), .endian_select(endian_select),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_addr(instr_addr), .instr_ack(instr_ack), .busy(busy),
        .done(done), .data_abort(data_abort), .mem_req(mem_req),
        .mem_write(mem_write), .mem_half(mem_half), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .cyc_type(cyc_type), .mem_rdata(mem_rdata),
        .fault_input(fault_input), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    hbls_mem_model u_mem (.mclk(mclk), .rst(rst), .mem_req(mem_req),
        .mem_write(mem_write), .rd_word(rd_word), .fault_cmd(fault_cmd),
        .mem_rdata(mem_rdata), .fault_input(fault_input));
    always @(posedge mclk)
        if (mem_req)
        begin
            cap_addr <= mem_addr;
            cap_wd <= mem_wdata;
            cap_half <= mem_half;
        end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= {1'b0, a};
        reg_wdata <= v;
        rv[a] = v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd_reg
    function automatic logic [31:0] exp_load(input logic [31:0] w,
        input logic [1:0] a, input logic big, s, h);
        logic [15:0] hw;
        logic [7:0] bt;
        int k;
        hw = (a[1] ^ big) ? w[31:16] : w[15:0];
        k = big ? 3 - a : a;
        bt = w[8*k +: 8];
        if (!h)
            return {{24{bt[7]}}, bt};
        return {{16{s & hw[15]}}, hw};
    endfunction : exp_load
    // op: 0 unsigned half load, 1 signed half load, 2 signed byte, 3 store
    task automatic do_op(input int op, input logic p, u, w, im,
        input logic [3:0] b, d, x, input logic flt);
        logic [31:0] iw, ia, bv, ov, mw, adr, md, got, sv, ev, lm;
        logic s, h, l, big;
        int n;
        s = op == 1 || op == 2;
        h = op != 2;
        l = op != 3;
        big = 1'($urandom);
        endian_select <= big;
        ia = $urandom & 32'hFFFF_FFFC;
        bv = ($urandom & 32'h0000_FFF0) | 32'h0001_0000;
        ov = $urandom & (h ? 32'hFE : 32'hFF);
        mw = $urandom;
        if (b != 4'hF)
            wr_reg(b, bv);
        else
            bv = ia + 32'h8;
        if (!im)
            wr_reg(x, ov);
        if (d != 4'hF)
            wr_reg(d, $urandom);
        iw = {4'hE, 3'b000, p, u, im, w, l, b, d, im ? ov[7:4] : 4'h0,
            1'b1, s, h, 1'b1, im ? ov[3:0] : x};
        md = u ? bv + ov : bv - ov;
        adr = p ? md : bv;
        rd_word <= mw;
        fault_cmd <= flt;
        repeat (3) @(posedge mclk);
        instr_valid <= 1'b1;
        instr_word <= iw;
        instr_addr <= ia;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (!instr_ack && n < 20);
        @(posedge mclk);
        instr_valid <= 1'b0;
        n = 1;
        #1;
        while (!(done || data_abort) && n < 30)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("cycles", flt || !l ? 3 : (d == 4'hF ? 6 : 4), n);
        chk("abort", {31'h0, flt}, {31'h0, data_abort});
        if (!(l && d == 4'hF))
            chk("address", adr, cap_addr);
        chk("size", {31'h0, h}, {31'h0, cap_half});
        sv = d == 4'hF ? ia + 32'hC : rv[d];
        if (!l)
            chk("store", {2{sv[15:0]}}, cap_wd);
        if (l && d != 4'hF)
        begin
            rd_reg({1'b0, d}, got);
            ev = flt ? rv[d] : exp_load(mw, adr[1:0], big, s, h);
            lm = h ? 32'hFFFF : 32'hFF;
            chk("dest", ev, got);
            chk("lane", ev & lm, got & lm);
        end
        if (b != 4'hF)
        begin
            rd_reg({1'b0, b}, got);
            chk("base", !flt && (!p || w) ? md : bv, got);
        end
        rd_reg(5'h11, got);
        chk("abort_flag", {30'h0, flt, 1'b0}, got & 32'h2);
        // clear the sticky flag so the next fault is seen on its own
        if (flt)
        begin
            @(posedge mclk);
            reg_wr <= 1'b1;
            reg_addr <= 5'h10;
            reg_wdata <= 32'h2;
            @(posedge mclk);
            reg_wr <= 1'b0;
        end
    endtask : do_op
    initial
    begin
        logic p;
        void'($urandom(53262));
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        do_op(0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 4'h6, 4'hA, 1'b0);
        do_op(3, 1'b1, 1'b0, 1'b0, 1'b1, 4'h2, 4'hF, 4'hA, 1'b0);
        do_op(1, 1'b1, 1'b1, 1'b0, 1'b1, 4'h3, 4'hF, 4'hA, 1'b0);
        do_op(2, 1'b0, 1'b0, 1'b0, 1'b0, 4'h4, 4'h7, 4'hB, 1'b1);
        do_op(3, 1'b1, 1'b1, 1'b1, 1'b1, 4'h5, 4'h8, 4'hC, 1'b1);
        for (int i = 0; i < 48; i++)
        begin
            p = 1'($urandom);
            do_op(int'($urandom % 4), p, 1'($urandom), p & 1'($urandom),
                1'($urandom), 4'(1 + $urandom % 5), 4'(6 + $urandom % 4),
                4'(10 + $urandom % 4), $urandom % 8 == 0);
        end
        wrap_up();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
endmodule : tb_halfword_byte_load_store
`default_nettype wire
